/* rtl/sdtr_regs.svh */
// timing counts and widths for the dram command-timing block
`ifndef SDTR_REGS_SVH
`define SDTR_REGS_SVH

`define SDTR_CLK_PERIOD_PS        8000
`define SDTR_ROW_ACTIVE_NS        40
`define SDTR_ROW_ACTIVE_CYC       ((`SDTR_ROW_ACTIVE_NS * 1000 + `SDTR_CLK_PERIOD_PS - 1) / `SDTR_CLK_PERIOD_PS)
`define SDTR_TERM_OFF_HALF_CLKS   5
`define SDTR_TERM_OFF_CYC         ((`SDTR_TERM_OFF_HALF_CLKS + 1) / 2)
`define SDTR_PREFETCH_BITS        4
`define SDTR_REFRESH_PER_WINDOW   8192
`define SDTR_REFRESH_CNT_W        13
`define SDTR_MAX_READ_LATENCY     8
`define SDTR_BANKS                4

`endif

/* rtl/sdtr_pkg.sv */
// command and state types for the dram command-timing block
package sdtr_pkg;

  typedef enum logic [2:0] {
    SDTR_CMD_NOP    = 3'h0,
    SDTR_CMD_ACT    = 3'h1,
    SDTR_CMD_RD     = 3'h2,
    SDTR_CMD_WR     = 3'h3,
    SDTR_CMD_PRE    = 3'h4,
    SDTR_CMD_PREALL = 3'h5,
    SDTR_CMD_REF    = 3'h6
  } sdtr_cmd_e;

  typedef enum logic [1:0] {
    SDTR_BANK_IDLE    = 2'h0,
    SDTR_BANK_ACTIVE  = 2'h1,
    SDTR_BANK_PENDING = 2'h2
  } sdtr_bank_state_e;

endpackage

/* rtl/sdtr_bank_timer.sv */
// per-bank row-active lockout with deferred internal precharge
`timescale 1ns/1ps
`include "sdtr_regs.svh"
module sdtr_bank_timer #(
  parameter int ROW_CYC = `SDTR_ROW_ACTIVE_CYC
) (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic clkEn,
  input  wire logic activate,
  input  wire logic autoPrecharge,
  input  wire logic prechargeCmd,
  output logic      bankOpen,
  output logic      lockoutActive,
  output logic      internalPrecharge
);
  import sdtr_pkg::*;

  localparam int CW = $clog2(ROW_CYC + 1);

  sdtr_bank_state_e state_r;
  sdtr_bank_state_e state_nxt;
  logic [CW-1:0]    rasCnt_r;
  logic [CW-1:0]    rasCnt_nxt;
  logic             preFire_r;
  logic             preFire_nxt;

  // row-active countdown and deferred precharge
  always_comb begin
    state_nxt   = state_r;
    rasCnt_nxt  = (rasCnt_r != '0) ? rasCnt_r - 1'b1 : rasCnt_r;
    preFire_nxt = 1'b0;
    unique case (state_r)
      SDTR_BANK_IDLE: begin
        if (activate) begin
          state_nxt  = SDTR_BANK_ACTIVE;
          rasCnt_nxt = CW'(ROW_CYC);
        end
      end
      SDTR_BANK_ACTIVE: begin
        if (prechargeCmd) begin
          state_nxt = SDTR_BANK_IDLE; // explicit close: spacing is the controller's duty
        end else if (autoPrecharge && rasCnt_r <= CW'(1)) begin
          state_nxt   = SDTR_BANK_IDLE;
          preFire_nxt = 1'b1;
        end else if (autoPrecharge) begin
          state_nxt = SDTR_BANK_PENDING;
        end
      end
      SDTR_BANK_PENDING: begin
        // hold the internal precharge until the row has been open long enough
        if (rasCnt_r <= CW'(1)) begin
          state_nxt   = SDTR_BANK_IDLE;
          preFire_nxt = 1'b1;
        end
      end
      default: begin
        state_nxt = SDTR_BANK_IDLE;
      end
    endcase
  end

  // frozen while clock enable is low
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_r   <= SDTR_BANK_IDLE;
      rasCnt_r  <= '0;
      preFire_r <= 1'b0;
    end else if (clkEn) begin
      state_r   <= state_nxt;
      rasCnt_r  <= rasCnt_nxt;
      preFire_r <= preFire_nxt;
    end
  end

  assign bankOpen          = (state_r != SDTR_BANK_IDLE);
  assign lockoutActive     = (state_r == SDTR_BANK_PENDING);
  assign internalPrecharge = preFire_r;

  // lockout checks
  AST_NO_EARLY_PRECHARGE: assert property (@(posedge clock) disable iff (!rst_b)
    (clkEn && activate && state_r == SDTR_BANK_IDLE) |=> !preFire_r [*3])
    else $error("internal precharge fired inside row-active time");

  AST_PENDING_RESOLVES: assert property (@(posedge clock) disable iff (!rst_b || !clkEn)
    (state_r == SDTR_BANK_PENDING && rasCnt_r <= CW'(1)) |=> preFire_r && !bankOpen)
    else $error("pending precharge not issued when row time elapsed");

  COV_LOCKOUT_USED: cover property (@(posedge clock) disable iff (!rst_b)
    state_r == SDTR_BANK_PENDING ##[1:20] preFire_r);

endmodule

/* rtl/sdtr_device_timing.sv */
// device-side command timing: refresh, auto-precharge lockout, read latency, termination turn-off
// Function
// - back-to-back refresh commands are accepted while clock enable is high
// - internal precharge held until row time met
// - read prefetched, data out after latency
// - termination removal begins 3 clocks after deassert (2.5 rounded up)
`timescale 1ns/1ps
`include "sdtr_regs.svh"
module sdtr_device_timing #(
  parameter int DQ_WIDTH = 4,
  parameter int ROW_CYC  = `SDTR_ROW_ACTIVE_CYC,
  parameter int MAX_LAT  = `SDTR_MAX_READ_LATENCY
) (
  input  wire logic                                    clock,
  input  wire logic                                    rst_b,
  input  wire logic                                    clkEn,
  input  wire logic                                    cmdValid,
  input  wire sdtr_pkg::sdtr_cmd_e                     cmdKind,
  input  wire logic [1:0]                              cmdBank,
  input  wire logic                                    cmdAutoPrecharge,
  input  wire logic [`SDTR_PREFETCH_BITS*DQ_WIDTH-1:0] arrayReadWord,
  input  wire logic [3:0]                              read_latency_clocks,
  input  wire logic                                    on_die_termination_control,
  output logic [`SDTR_BANKS-1:0]                       bankOpen,
  output logic [`SDTR_BANKS-1:0]                       bankLockout,
  output logic [`SDTR_BANKS-1:0]                       internalPrecharge,
  output logic                                         refreshAck,
  output logic [`SDTR_REFRESH_CNT_W-1:0]               refreshCount,
  output logic                                         readValid,
  output logic [`SDTR_PREFETCH_BITS*DQ_WIDTH-1:0]      readData,
  output logic                                         terminationOn
);
  import sdtr_pkg::*;

  localparam int WW = `SDTR_PREFETCH_BITS * DQ_WIDTH;
  localparam int TW = $clog2(`SDTR_TERM_OFF_CYC + 1);

  // command decode, shared by every bank
  function automatic logic hit(input sdtr_cmd_e kind, input logic [1:0] bank,
                               input sdtr_cmd_e want, input int idx);
    hit = cmdValid && (kind == want) && (bank == 2'(idx));
  endfunction

  // per-bank lockout timers
  genvar gb;
  generate
    for (gb = 0; gb < `SDTR_BANKS; gb++) begin : g_bank
      logic accessAp;
      assign accessAp = cmdAutoPrecharge && (hit(cmdKind, cmdBank, SDTR_CMD_RD, gb) ||
                                             hit(cmdKind, cmdBank, SDTR_CMD_WR, gb));
      sdtr_bank_timer #(
        .ROW_CYC (ROW_CYC)
      ) u_timer (
        .clock             (clock),
        .rst_b             (rst_b),
        .clkEn             (clkEn),
        .activate          (hit(cmdKind, cmdBank, SDTR_CMD_ACT, gb)),
        .autoPrecharge     (accessAp),
        .prechargeCmd      (hit(cmdKind, cmdBank, SDTR_CMD_PRE, gb) ||
                            (cmdValid && cmdKind == SDTR_CMD_PREALL)),
        .bankOpen          (bankOpen[gb]),
        .lockoutActive     (bankLockout[gb]),
        .internalPrecharge (internalPrecharge[gb])
      );
    end
  endgenerate

  // refresh: no minimum spacing, so a burst is taken one per cycle
  logic                           refAck_r;
  logic                           refAck_nxt;
  logic [`SDTR_REFRESH_CNT_W-1:0] refCnt_r;
  logic [`SDTR_REFRESH_CNT_W-1:0] refCnt_nxt;

  always_comb begin
    refAck_nxt = cmdValid && (cmdKind == SDTR_CMD_REF);
    refCnt_nxt = refAck_nxt ? refCnt_r + 1'b1 : refCnt_r; // wraps after a full window of rows
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      refAck_r <= 1'b0;
      refCnt_r <= '0;
    end else if (clkEn) begin
      refAck_r <= refAck_nxt;
      refCnt_r <= refCnt_nxt;
    end
  end

  assign refreshAck   = refAck_r;
  assign refreshCount = refCnt_r;

  // read latency line: entry lands at slot latency-1 and drains to slot 0,
  // so the output is always a flop and no wide mux sits on it
  logic [WW-1:0]      pipeData_r [MAX_LAT];
  logic [WW-1:0]      pipeData_nxt [MAX_LAT];
  logic [MAX_LAT-1:0] pipeValid_r;
  logic [MAX_LAT-1:0] pipeValid_nxt;
  logic               readHit;
  logic [3:0]         latClamped;

  always_comb begin
    readHit    = cmdValid && (cmdKind == SDTR_CMD_RD);
    latClamped = (read_latency_clocks == 4'h0) ? 4'h1 :
                 (read_latency_clocks > 4'(MAX_LAT)) ? 4'(MAX_LAT) : read_latency_clocks;
    for (int i = 0; i < MAX_LAT; i++) begin
      pipeData_nxt[i]  = (i + 1 < MAX_LAT) ? pipeData_r[(i + 1) % MAX_LAT] : '0;
      pipeValid_nxt[i] = (i + 1 < MAX_LAT) ? pipeValid_r[(i + 1) % MAX_LAT] : 1'b0;
      if (readHit && (4'(i) == latClamped - 4'h1)) begin
        pipeData_nxt[i]  = arrayReadWord;
        pipeValid_nxt[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < MAX_LAT; i++) begin
        pipeData_r[i] <= '0;
      end
      pipeValid_r <= '0;
    end else if (clkEn) begin
      for (int i = 0; i < MAX_LAT; i++) begin
        pipeData_r[i] <= pipeData_nxt[i];
      end
      pipeValid_r <= pipeValid_nxt;
    end
  end

  assign readValid = pipeValid_r[0];
  assign readData  = pipeData_r[0];

  // termination pin synchroniser: a change counts when stages two and three agree
  logic          termS1_r;
  logic          termS2_r;
  logic          termS3_r;
  logic          termLevel_r;
  logic          termLevel_nxt;
  logic          termOn_r;
  logic          termOn_nxt;
  logic [TW-1:0] termCnt_r;
  logic [TW-1:0] termCnt_nxt;

  // half-clock of the delay is rounded up to a whole cycle; duty cycle cannot be seen here
  always_comb begin
    termLevel_nxt = (termS2_r == termS3_r) ? termS3_r : termLevel_r;
    termOn_nxt    = termOn_r;
    termCnt_nxt   = termCnt_r;
    if (termLevel_nxt) begin
      termOn_nxt  = 1'b1;
      termCnt_nxt = '0;
    end else if (termLevel_r) begin
      termCnt_nxt = TW'(`SDTR_TERM_OFF_CYC);
    end else if (termCnt_r != '0) begin
      termCnt_nxt = termCnt_r - 1'b1;
      if (termCnt_r == TW'(1)) begin
        termOn_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      termS1_r    <= 1'b0;
      termS2_r    <= 1'b0;
      termS3_r    <= 1'b0;
      termLevel_r <= 1'b0;
      termOn_r    <= 1'b0;
      termCnt_r   <= '0;
    end else if (clkEn) begin
      termS1_r    <= on_die_termination_control;
      termS2_r    <= termS1_r;
      termS3_r    <= termS2_r;
      termLevel_r <= termLevel_nxt;
      termOn_r    <= termOn_nxt;
      termCnt_r   <= termCnt_nxt;
    end
  end

  assign terminationOn = termOn_r;

  // checks
  AST_REFRESH_BURST: assert property (@(posedge clock) disable iff (!rst_b || !clkEn)
    (cmdValid && cmdKind == SDTR_CMD_REF) |=> refreshAck && refreshCount == $past(refreshCount) + 1'b1)
    else $error("refresh command not accepted");

  AST_READ_LAT3: assert property (@(posedge clock) disable iff (!rst_b || !clkEn)
    (readHit && read_latency_clocks == 4'h3) |-> ##3 (readValid && readData == $past(arrayReadWord, 3)))
    else $error("read data not presented at programmed latency");

  AST_READ_NOT_EARLY: assert property (@(posedge clock) disable iff (!rst_b || !clkEn)
    (readHit && read_latency_clocks == 4'h4 && pipeValid_r == '0) |=> !readValid [*3])
    else $error("read data appeared before latency");

  AST_TERM_OFF_DELAY: assert property (@(posedge clock) disable iff (!rst_b || !clkEn)
    ($fell(termLevel_r) && termOn_r) |-> (termOn_r && !termLevel_r) [*3] ##1 !termOn_r or
    ##[1:3] termLevel_r)
    else $error("termination turn-off delay wrong");

  COV_REFRESH_BURST: cover property (@(posedge clock) disable iff (!rst_b)
    refreshAck [*4]);
  COV_READ: cover property (@(posedge clock) disable iff (!rst_b)
    readHit ##[1:8] readValid);
  COV_TERM_OFF: cover property (@(posedge clock) disable iff (!rst_b)
    $fell(terminationOn));

endmodule

/* sim/sdtr_ctrl_model.sv */
// controller-side command model driving the timing block
`timescale 1ns/1ps
`include "sdtr_regs.svh"
module sdtr_ctrl_model #(
  parameter int ROW_CYC       = `SDTR_ROW_ACTIVE_CYC,
  parameter int CLK_PS        = `SDTR_CLK_PERIOD_PS,
  parameter int SINGLE_PRE_PS = 16000,
  parameter int ALL_PRE_PS    = 16000,
  parameter int READ_PRE_PS   = 7500,
  parameter int ADD_LAT       = 0,
  parameter int BURST_LEN     = 4,
  parameter int WR_CLOCKS     = 2
) (
  input  wire logic           clock,
  output logic                clkEn,
  output logic                cmdValid,
  output sdtr_pkg::sdtr_cmd_e cmdKind,
  output logic [1:0]          cmdBank,
  output logic                cmdAutoPrecharge,
  output logic [15:0]         arrayReadWord,
  output logic [3:0]          read_latency_clocks,
  output logic                on_die_termination_control
);
  import sdtr_pkg::*;

  int bankWait [4]; // clocks each bank still owes before its next activate or precharge

  // countdowns follow the block's own time, so they stop while it is frozen
  always @(posedge clock) begin
    foreach (bankWait[i]) begin
      if (clkEn && bankWait[i] > 0) bankWait[i] <= bankWait[i] - 1;
    end
  end

  // write-recovery clocks plus the precharge period rounded up to whole clocks
  function automatic int ap_write_to_activate(input int wrClocks, input int prePs, input int clkPs);
    return wrClocks + (prePs + clkPs - 1) / clkPs;
  endfunction

  // short read-to-precharge times fall back to the burst rule; long ones count from the last prefetch
  function automatic int read_to_precharge(input int addLat, input int burstLen, input int rtpPs, input int clkPs);
    if (rtpPs <= 2 * clkPs) begin
      return addLat + burstLen / 2;
    end
    return addLat + burstLen / 2 - 2 + (rtpPs + clkPs - 1) / clkPs;
  endfunction

  // true while any addressed bank still owes spacing
  function automatic logic busy(input logic all, input logic [1:0] b);
    busy = 1'h0;
    for (int i = 0; i < 4; i++) begin
      if ((all || b == 2'(i)) && bankWait[i] != 0) begin
        busy = 1'h1;
      end
    end
  endfunction

  // clock enable starts high; every later level is held through three rising edges
  initial begin
    clkEn = 1'h1;
    cmdValid = 1'h0;
    cmdKind = SDTR_CMD_NOP;
    cmdBank = 2'h0;
    cmdAutoPrecharge = 1'h0;
    arrayReadWord = 16'h0000;
    read_latency_clocks = 4'h3;
    on_die_termination_control = 1'h0;
  end
  // one command per falling edge, back to back allowed
  task automatic send(input sdtr_cmd_e k, input logic [1:0] b, input logic ap, input logic [15:0] w);
    @(negedge clock);
    cmdValid = 1'h1;
    cmdKind = k;
    cmdBank = b;
    cmdAutoPrecharge = ap;
    arrayReadWord = w;
  endtask
  // released fields flip so a stale value is never mistaken for a live one
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge clock);
      cmdValid = 1'h0;
      cmdKind = SDTR_CMD_NOP;
      cmdBank = ~cmdBank;
      cmdAutoPrecharge = ~cmdAutoPrecharge;
      arrayReadWord = ~arrayReadWord;
    end
  endtask
  // new level and an idle bus together, then two more edges so three edges see it
  task automatic set_clock_enable(input logic level);
    @(negedge clock);
    clkEn = level;
    cmdValid = 1'h0;
    cmdKind = SDTR_CMD_NOP;
    idle(2);
  endtask
  // settings change in the time step of the last negedge
  task automatic set_latency(input logic [3:0] lat);
    read_latency_clocks = lat;
  endtask
  task automatic set_termination(input logic level);
    on_die_termination_control = level;
  endtask
  // activate waits out the spacing the bank owes, then books the row-active time
  task automatic activate(input logic [1:0] b);
    while (busy(1'h0, b)) idle(1);
    send(SDTR_CMD_ACT, b, 1'h0, arrayReadWord);
    bankWait[b] = ROW_CYC;
  endtask
  // read that books the spacing a later precharge to the same bank needs
  task automatic read_word(input logic [1:0] b, input logic [15:0] w);
    send(SDTR_CMD_RD, b, 1'h0, w);
    if (bankWait[b] < read_to_precharge(ADD_LAT, BURST_LEN, READ_PRE_PS, CLK_PS)) begin
      bankWait[b] = read_to_precharge(ADD_LAT, BURST_LEN, READ_PRE_PS, CLK_PS);
    end
  endtask
  // the bank may not reopen before write recovery plus precharge have passed
  task automatic write_autoprecharge(input logic [1:0] b);
    send(SDTR_CMD_WR, b, 1'h1, arrayReadWord);
    bankWait[b] = ap_write_to_activate(WR_CLOCKS, SINGLE_PRE_PS, CLK_PS);
  endtask
  // precharge waits for the addressed banks, then books the single or all-bank period
  task automatic precharge(input logic all, input logic [1:0] b);
    int cyc;
    cyc = ((all ? ALL_PRE_PS : SINGLE_PRE_PS) + CLK_PS - 1) / CLK_PS;
    while (busy(all, b)) idle(1);
    if (all) begin
      send(SDTR_CMD_PREALL, b, 1'h0, arrayReadWord);
    end else begin
      send(SDTR_CMD_PRE, b, 1'h0, arrayReadWord);
    end
    for (int i = 0; i < 4; i++) begin
      if (all || b == 2'(i)) begin
        bankWait[i] = cyc;
      end
    end
  endtask
endmodule

/* sim/testbench.sv */
// self-checking bench for the dram command-timing block
`timescale 1ns/1ps
module testbench;
  import sdtr_pkg::*;
  localparam int ROW = 5;
  logic        clock = 1'h0;
  logic        rst_b = 1'h0;
  logic        clkEn, cmdValid, cmdAutoPrecharge, on_die_termination_control;
  logic        refreshAck, readValid, terminationOn;
  sdtr_cmd_e   cmdKind;
  logic [1:0]  cmdBank;
  logic [3:0]  read_latency_clocks, bankOpen, bankLockout, internalPrecharge;
  logic [15:0] arrayReadWord, readData;
  logic [12:0] refreshCount;
  int          mismatches = 0;
  int          totalChecks = 0;

  sdtr_ctrl_model #(
    .ROW_CYC (ROW)
  ) ctrl (
    .clock                      (clock),
    .clkEn                      (clkEn),
    .cmdValid                   (cmdValid),
    .cmdKind                    (cmdKind),
    .cmdBank                    (cmdBank),
    .cmdAutoPrecharge           (cmdAutoPrecharge),
    .arrayReadWord              (arrayReadWord),
    .read_latency_clocks        (read_latency_clocks),
    .on_die_termination_control (on_die_termination_control)
  );
  sdtr_device_timing #(
    .ROW_CYC (ROW)
  ) dut (
    .clock                      (clock),
    .rst_b                      (rst_b),
    .clkEn                      (clkEn),
    .cmdValid                   (cmdValid),
    .cmdKind                    (cmdKind),
    .cmdBank                    (cmdBank),
    .cmdAutoPrecharge           (cmdAutoPrecharge),
    .arrayReadWord              (arrayReadWord),
    .read_latency_clocks        (read_latency_clocks),
    .on_die_termination_control (on_die_termination_control),
    .bankOpen                   (bankOpen),
    .bankLockout                (bankLockout),
    .internalPrecharge          (internalPrecharge),
    .refreshAck                 (refreshAck),
    .refreshCount               (refreshCount),
    .readValid                  (readValid),
    .readData                   (readData),
    .terminationOn              (terminationOn)
  );

  // 8 ns period
  always #4 clock = ~clock;

  // four-state compare, so an unknown never passes
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    totalChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    if (mismatches == 0 && totalChecks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // three refreshes back to back, then a full window of 8192 wraps the count
  task automatic test_refresh();
    logic [12:0] base;
    base = refreshCount;
    ctrl.send(SDTR_CMD_REF, 2'h0, 1'h0, 16'h0000);
    repeat (2) begin
      ctrl.send(SDTR_CMD_REF, 2'h0, 1'h0, 16'h0000);
      chk(refreshAck, 1'h1);
    end
    ctrl.idle(1);
    chk(refreshAck, 1'h1);
    ctrl.idle(1);
    chk(refreshAck, 1'h0);
    chk(refreshCount, base + 13'h0003);
    repeat (8189) ctrl.send(SDTR_CMD_REF, 2'h0, 1'h0, 16'h0000);
    ctrl.idle(1);
    chk(refreshCount, base);
  endtask

  // latencies 0, 1, 3, 4, 8 and 12 incl. clamped ends; data must be the word sampled with the command
  task automatic test_read();
    logic [3:0] lats [6];
    int eff;
    lats = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h8, 4'hC};
    foreach (lats[i]) begin
      ctrl.idle(1);
      ctrl.set_latency(lats[i]);
      eff = (lats[i] == 4'h0) ? 1 : (lats[i] > 4'h8) ? 8 : int'(lats[i]);
      ctrl.read_word(2'h1, 16'hA5C0 + 16'(i));
      for (int k = 1; k <= eff + 1; k++) begin
        ctrl.idle(1);
        chk(readValid, 1'(k == eff));
        if (k == eff) chk(readData, 16'hA5C0 + 16'(i));
      end
    end
  endtask

  // auto precharge right after activate is held until the row time runs out
  task automatic test_lockout();
    ctrl.send(SDTR_CMD_ACT, 2'h1, 1'h0, 16'h0000);
    ctrl.send(SDTR_CMD_RD, 2'h1, 1'h1, 16'h0000);
    chk(bankOpen, 4'h2);
    for (int k = 2; k <= ROW; k++) begin
      ctrl.idle(1);
      chk({bankLockout[1], internalPrecharge[1]}, 2'h2);
    end
    ctrl.idle(1);
    chk({bankOpen, bankLockout, internalPrecharge}, 12'h002);
    ctrl.idle(1);
    chk(internalPrecharge, 4'h0);
  endtask

  // late auto precharge fires next cycle; explicit precharges close at once, no pulse
  task automatic test_close();
    chk(16'(ctrl.ap_write_to_activate(4, 15000, 3750)), 16'h0008);
    chk(16'(ctrl.read_to_precharge(0, 8, 7500, 3000)), 16'h0005);
    ctrl.activate(2'h2);
    ctrl.activate(2'h3);
    ctrl.idle(ROW + 1);
    ctrl.write_autoprecharge(2'h3);
    ctrl.idle(1);
    chk({bankOpen, internalPrecharge}, 8'h48);
    ctrl.precharge(1'h0, 2'h2);
    ctrl.idle(1);
    chk({bankOpen, internalPrecharge}, 8'h00);
    ctrl.activate(2'h0);
    ctrl.activate(2'h1);
    ctrl.precharge(1'h1, 2'h2);
    ctrl.idle(1);
    chk({bankOpen, internalPrecharge}, 8'h00);
  endtask

  // termination passes the synchroniser, then lingers after release
  task automatic test_term();
    int n;
    ctrl.idle(1);
    ctrl.set_termination(1'h1);
    n = 0;
    while (terminationOn !== 1'h1 && n < 10) begin
      ctrl.idle(1);
      n++;
    end
    chk(n < 6, 1'h1);
    ctrl.set_termination(1'h0);
    n = 0;
    while (terminationOn === 1'h1 && n < 20) begin
      ctrl.idle(1);
      n++;
    end
    chk(n >= 5 && n <= 8, 1'h1);
  endtask

  // clock enable low freezes the pulse in flight and drops commands given meanwhile
  task automatic test_freeze();
    logic [12:0] base;
    base = refreshCount;
    ctrl.send(SDTR_CMD_REF, 2'h0, 1'h0, 16'h0000);
    ctrl.set_clock_enable(1'h0);
    chk(refreshAck, 1'h1);
    chk(refreshCount, base + 13'h0001);
    ctrl.send(SDTR_CMD_REF, 2'h0, 1'h0, 16'h0000);
    ctrl.set_clock_enable(1'h1);
    chk(refreshAck, 1'h0);
    chk(refreshCount, base + 13'h0001);
  endtask

  // reset for 16 cycles, then the scenarios in turn
  initial begin
    repeat (16) @(negedge clock);
    chk({bankOpen, refreshAck, readValid, terminationOn}, 7'h00);
    rst_b = 1'h1;
    test_refresh();
    test_read();
    test_lockout();
    test_close();
    test_term();
    test_freeze();
    stop_test();
  end

  // a hang counts against the run; normal run is near 70 us
  initial begin
    #200000;
    mismatches++;
    stop_test();
  end
endmodule
